// >>> rtl/csw_osc_mon.sv
// Slow oscillator loss detector
`timescale 1ns/10ps
`default_nettype none

module csw_osc_mon #(
  parameter int unsigned FAIL_CYC = csw_pkg::OSC_FAIL_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_in,
  input wire logic enable,
  output logic fail
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic fail;
    logic [31:0] cnt;
  } csw_osc_t;

  csw_osc_t st_r;
  csw_osc_t st_nxt;

  // ---------------------------------------------------------------
  // Edge watch
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = osc_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2;
    if (!enable)
    begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.fail = 1'b0;
    end
    else if (st_r.s2 != st_r.prev)
    begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.fail = 1'b0;
    end
    else if (st_r.cnt >= FAIL_CYC - 1)
    begin
      st_nxt.fail = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{s1: 1'b0, s2: 1'b0, prev: 1'b0, fail: 1'b0, cnt: 32'h0000_0000};
    else
      st_r <= st_nxt;
  end

  assign fail = st_r.fail;

endmodule

`default_nettype wire

// >>> rtl/csw_pin_filter.sv
// Pin synchroniser with a minimum-low-time filter
`timescale 1ns/10ps
`default_nettype none

module csw_pin_filter #(
  parameter int unsigned HOLD = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic [15:0] cnt;
  } csw_filt_t;

  csw_filt_t st_r;
  csw_filt_t st_nxt;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------
  // Highs pass at once; a low must last HOLD cycles, so short glitches die here
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2)
    begin
      st_nxt.cnt = 16'h0000;
      st_nxt.out = 1'b1;
    end
    else if (32'(st_r.cnt) >= HOLD - 1)
    begin
      st_nxt.out = 1'b0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 16'h0000};
    else
      st_r <= st_nxt;
  end

  assign level = st_r.out;

endmodule

`default_nettype wire

// >>> rtl/csw_pkg.sv
// Package of constants for the supervisor and watchdog block
package csw_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 250_000_000;
  localparam longint CLK_NS = 4;

  localparam longint MR_MIN_NS = 1000;
  localparam int unsigned MR_MIN_CYC = 32'((MR_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam longint MR_GLITCH_NS = 35;
  localparam int unsigned MR_GLITCH_CYC = 32'(MR_GLITCH_NS / CLK_NS);

  localparam longint OSC_HZ = 32768;
  localparam longint OSC_FAIL_PERIODS = 30;
  localparam int unsigned OSC_FAIL_CYC = 32'((OSC_FAIL_PERIODS * CLK_HZ + OSC_HZ - 1) / OSC_HZ);

  localparam longint WD_LONG_MS = 1600;
  localparam longint WD_SHORT_MS = 200;
  localparam int unsigned WD_LONG_CYC = 32'(WD_LONG_MS * CLK_HZ / 1000);
  localparam int unsigned WD_SHORT_CYC = 32'(WD_SHORT_MS * CLK_HZ / 1000);

  localparam longint RST_TIMEOUT_MS = 150;
  localparam int unsigned RST_TIMEOUT_CYC = 32'(RST_TIMEOUT_MS * CLK_HZ / 1000);

  localparam longint BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYC = 32'(BLINK_HALF_MS * CLK_HZ / 1000);

  localparam longint WRITE_COMPLETION_NS = 10000;
  localparam int unsigned WRITE_COMPLETION_CYC = 32'(WRITE_COMPLETION_NS / CLK_NS);

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  localparam int WD_PERIOD_POS = 2;
  localparam int WATCHDOG_ENABLE_BIT_POS = 3;
  localparam int BLINK_POS = 4;
  localparam int OSC_EN_POS = 6;
  localparam logic [7:0] CTRL_RST = 8'h48;

  localparam int OSC_FAIL_POS = 0;
  localparam int RST_ACTIVE_POS = 1;
  localparam int ON_BACKUP_POS = 2;

  localparam int PLAIN_PINS = 4;

endpackage

// >>> rtl/csw_top.sv
// Processor supervisor: watchdog, reset timer, crystal check, backup flag, chip-enable gate
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module csw_top #(
  parameter int unsigned WD_LONG_CYC = csw_pkg::WD_LONG_CYC,
  parameter int unsigned WD_SHORT_CYC = csw_pkg::WD_SHORT_CYC,
  parameter int unsigned RST_TIMEOUT_CYC = csw_pkg::RST_TIMEOUT_CYC,
  parameter int unsigned BLINK_HALF_CYC = csw_pkg::BLINK_HALF_CYC,
  parameter int unsigned OSC_FAIL_CYC = csw_pkg::OSC_FAIL_CYC,
  parameter int unsigned MR_MIN_CYC = csw_pkg::MR_MIN_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic osc_in,
  input wire logic supply_ok,
  input wire logic vcc_below_batt,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic ce_in_n,
  output logic ce_out_n,
  output logic reset_n_o,
  output logic reset_n_oe,
  output logic on_backup_supply_n_o,
  output logic on_backup_supply_n_oe,
  output logic serial_out_en
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic watchdog_period_bit;
    logic watchdog_enable_bit;
    logic backup_indicator_blink_bit;
    logic osc_enable_bit;
    logic osc_failure_flag;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rst_active;
    logic [31:0] rst_cnt;
    logic [31:0] wd_cnt;
    logic wd_prev;
    logic backup;
    logic blink_phase;
    logic [31:0] blink_cnt;
    logic rst_prev;
    logic ce_hold;
    logic [15:0] ce_cnt;
    logic ce_out_n;
  } csw_state_t;

  localparam csw_state_t ST_RST = '{
    watchdog_period_bit: csw_pkg::CTRL_RST[csw_pkg::WD_PERIOD_POS],
    watchdog_enable_bit: csw_pkg::CTRL_RST[csw_pkg::WATCHDOG_ENABLE_BIT_POS],
    backup_indicator_blink_bit: csw_pkg::CTRL_RST[csw_pkg::BLINK_POS],
    osc_enable_bit: csw_pkg::CTRL_RST[csw_pkg::OSC_EN_POS],
    osc_failure_flag: 1'b0,
    wr_pend: 1'b0,
    wr_addr: 8'h00,
    rdata: 32'h0000_0000,
    rst_active: 1'b1,
    rst_cnt: 32'h0000_0000,
    wd_cnt: 32'h0000_0000,
    wd_prev: 1'b0,
    backup: 1'b0,
    blink_phase: 1'b1,
    blink_cnt: 32'h0000_0000,
    rst_prev: 1'b1,
    ce_hold: 1'b0,
    ce_cnt: 16'h0000,
    ce_out_n: 1'b1
  };

  csw_state_t st_r;
  csw_state_t st_nxt;

  // ---------------------------------------------------------------
  // Pin conditioning
  // ---------------------------------------------------------------
  logic [csw_pkg::PLAIN_PINS-1:0] pin_raw;
  logic [csw_pkg::PLAIN_PINS-1:0] pin_s;
  logic mr_low_n;
  logic osc_fail;

  assign pin_raw = {ce_in_n, watchdog_kick_in, vcc_below_batt, supply_ok};

  genvar gi;
  generate
    for (gi = 0; gi < csw_pkg::PLAIN_PINS; gi = gi + 1)
    begin : g_pin
      csw_pin_filter #(
        .HOLD(1)
      ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(pin_raw[gi]),
        .level(pin_s[gi])
      );
    end
  endgenerate

  // Filter far longer than the glitch limit, so short lows never count
  csw_pin_filter #(
    .HOLD(MR_MIN_CYC)
  ) u_mr (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(manual_reset_n),
    .level(mr_low_n)
  );

  csw_osc_mon #(
    .FAIL_CYC(OSC_FAIL_CYC)
  ) u_osc (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_in(osc_in),
    .enable(st_r.osc_enable_bit),
    .fail(osc_fail)
  );

  logic supply_ok_s;
  logic below_batt_s;
  logic kick_s;
  logic ce_in_n_s;

  assign supply_ok_s = pin_s[0];
  assign below_batt_s = pin_s[1];
  assign kick_s = pin_s[2];
  assign ce_in_n_s = pin_s[3];

  // ---------------------------------------------------------------
  // Combinational terms
  // ---------------------------------------------------------------
  logic addr_acc;
  logic stat_read;
  logic kick_edge;
  logic [31:0] wd_limit;
  logic wd_expire;
  logic rst_source;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  assign addr_acc = hsel && htrans[1] && hready;
  assign stat_read = addr_acc && !hwrite && (haddr[7:0] == csw_pkg::STAT_OFS);
  // Kick edges only count outside reset
  assign kick_edge = (kick_s != st_r.wd_prev) && !st_r.rst_active;
  assign wd_limit = st_r.watchdog_period_bit ? WD_SHORT_CYC : WD_LONG_CYC;
  assign wd_expire = st_r.watchdog_enable_bit && !st_r.rst_active && !kick_edge
                     && (st_r.wd_cnt >= wd_limit - 1);
  assign rst_source = !supply_ok_s || !mr_low_n || wd_expire;

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[csw_pkg::WD_PERIOD_POS] = st_r.watchdog_period_bit;
    ctrl_word[csw_pkg::WATCHDOG_ENABLE_BIT_POS] = st_r.watchdog_enable_bit;
    ctrl_word[csw_pkg::BLINK_POS] = st_r.backup_indicator_blink_bit;
    ctrl_word[csw_pkg::OSC_EN_POS] = st_r.osc_enable_bit;
    stat_word = 32'h0000_0000;
    stat_word[csw_pkg::OSC_FAIL_POS] = st_r.osc_failure_flag;
    stat_word[csw_pkg::RST_ACTIVE_POS] = st_r.rst_active;
    stat_word[csw_pkg::ON_BACKUP_POS] = st_r.backup;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // Bus: zero wait states, read data registered at the address phase
    st_nxt.wr_pend = addr_acc && hwrite;
    if (addr_acc)
    begin
      st_nxt.wr_addr = haddr[7:0];
    end
    if (addr_acc && !hwrite)
    begin
      if (haddr[7:0] == csw_pkg::CTRL_OFS)
        st_nxt.rdata = ctrl_word;
      else if (haddr[7:0] == csw_pkg::STAT_OFS)
        st_nxt.rdata = stat_word;
      else
        st_nxt.rdata = 32'h0000_0000;
    end
    if (st_r.wr_pend && (st_r.wr_addr == csw_pkg::CTRL_OFS))
    begin
      st_nxt.watchdog_period_bit = hwdata[csw_pkg::WD_PERIOD_POS];
      st_nxt.watchdog_enable_bit = hwdata[csw_pkg::WATCHDOG_ENABLE_BIT_POS];
      st_nxt.backup_indicator_blink_bit = hwdata[csw_pkg::BLINK_POS];
      st_nxt.osc_enable_bit = hwdata[csw_pkg::OSC_EN_POS];
    end

    // Any reset condition forces the long period; watchdog reset also disables
    if (rst_source || st_r.rst_active)
    begin
      st_nxt.watchdog_period_bit = 1'b0;
    end
    if (wd_expire)
    begin
      st_nxt.watchdog_period_bit = 1'b0;
      st_nxt.watchdog_enable_bit = 1'b0;
    end

    // Crystal flag: a new failure wins over the clearing read
    st_nxt.osc_failure_flag = (st_r.osc_failure_flag && !stat_read) || osc_fail;

    // Reset timer restarts while any source stays active
    if (rst_source)
    begin
      st_nxt.rst_active = 1'b1;
      st_nxt.rst_cnt = 32'h0000_0000;
    end
    else if (st_r.rst_active)
    begin
      if (st_r.rst_cnt >= RST_TIMEOUT_CYC - 1)
        st_nxt.rst_active = 1'b0;
      else
        st_nxt.rst_cnt = st_r.rst_cnt + 32'h0000_0001;
    end

    // Watchdog counter
    st_nxt.wd_prev = kick_s;
    if (st_r.rst_active || !st_r.watchdog_enable_bit || kick_edge || wd_expire)
      st_nxt.wd_cnt = 32'h0000_0000;
    else
      st_nxt.wd_cnt = st_r.wd_cnt + 32'h0000_0001;

    // Backup supply: enter only when below both levels, leave on supply good
    if (supply_ok_s)
      st_nxt.backup = 1'b0;
    else if (below_batt_s)
      st_nxt.backup = 1'b1;

    if (!st_r.backup || !st_r.backup_indicator_blink_bit)
    begin
      st_nxt.blink_cnt = 32'h0000_0000;
      st_nxt.blink_phase = 1'b1;
    end
    else if (st_r.blink_cnt >= BLINK_HALF_CYC - 1)
    begin
      st_nxt.blink_cnt = 32'h0000_0000;
      st_nxt.blink_phase = !st_r.blink_phase;
    end
    else
    begin
      st_nxt.blink_cnt = st_r.blink_cnt + 32'h0000_0001;
    end

    // Chip-enable gate
    st_nxt.rst_prev = st_r.rst_active;
    if (!st_r.rst_active)
    begin
      st_nxt.ce_hold = 1'b0;
      st_nxt.ce_out_n = ce_in_n_s;
    end
    else if (!st_r.rst_prev && !st_r.ce_out_n)
    begin
      st_nxt.ce_hold = 1'b1;
      st_nxt.ce_cnt = 16'h0000;
      st_nxt.ce_out_n = 1'b0;
    end
    else if (st_r.ce_hold)
    begin
      // Ends at the write's own rising edge or at the delay, whichever first
      if (ce_in_n_s || (32'(st_r.ce_cnt) >= csw_pkg::WRITE_COMPLETION_CYC - 1))
      begin
        st_nxt.ce_hold = 1'b0;
        st_nxt.ce_out_n = 1'b1;
      end
      else
      begin
        st_nxt.ce_cnt = st_r.ce_cnt + 16'h0001;
      end
    end
    else
    begin
      st_nxt.ce_out_n = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= ST_RST;
    else
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign ce_out_n = st_r.ce_out_n;
  // Open-drain pins only ever pull low
  assign reset_n_o = 1'b0;
  assign reset_n_oe = st_r.rst_active;
  assign on_backup_supply_n_o = 1'b0;
  assign on_backup_supply_n_oe = st_r.backup && st_r.blink_phase;
  assign serial_out_en = !st_r.rst_active;

endmodule

`default_nettype wire

// >>> sim/csw_host_model.sv
// Host side model: crystal source and watchdog kicking
`timescale 1ns/10ps
`default_nettype none

module csw_host_model (
  input wire logic hclk,
  input wire logic osc_run,
  input wire logic kick_run,
  output logic osc_in,
  output logic watchdog_kick_in
);
  int ph;
  initial
  begin
    osc_in = 1'b0;
    watchdog_kick_in = 1'b0;
    ph = 0;
  end
  // Stopped crystal stands still, like a dead one
  always @(posedge hclk)
  begin
    ph <= ph + 1;
    if (osc_run && ph % 3 == 0)
      osc_in <= !osc_in;
    if (kick_run && ph % 10 == 0)
      watchdog_kick_in <= !watchdog_kick_in;
  end
endmodule
`default_nettype wire

// >>> sim/csw_top_assertions.sv
// Port checker of the supervisor block
`timescale 1ns/10ps
`default_nettype none

module csw_top_checker #(
  parameter int unsigned RST_TIMEOUT_CYC = 100,
  parameter int unsigned MR_MIN_CYC = 250
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic supply_ok,
  input wire logic manual_reset_n,
  input wire logic ce_in_n,
  input wire logic ce_out_n,
  input wire logic reset_n_o,
  input wire logic reset_n_oe,
  input wire logic on_backup_supply_n_o,
  input wire logic on_backup_supply_n_oe,
  input wire logic serial_out_en
);
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  localparam int DRAIN = int'(csw_pkg::WRITE_COMPLETION_CYC) + 10;
  int mr_low;
  int hold_cnt;
  int rst_cnt;
  // Margin of 8 on the filter: sync latency is not a rule
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mr_low <= 0;
      hold_cnt <= 0;
      rst_cnt <= 0;
    end
    else
    begin
      mr_low <= manual_reset_n ? 0 : mr_low + int'(mr_low < 999);
      hold_cnt <= (!supply_ok || mr_low > int'(MR_MIN_CYC) + 8) ? 0 : hold_cnt + int'(hold_cnt < 999);
      rst_cnt <= reset_n_oe ? rst_cnt + int'(rst_cnt < 9999) : 0;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_OD_LOW: assert property (!reset_n_o && !on_backup_supply_n_o)
    else $error("open-drain pin data not low");
  AST_RDATA_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_SER_OFF: assert property (serial_out_en == !reset_n_oe)
    else $error("serial output enable not the inverse of reset");
  AST_REL_SRC: assert property ($fell(reset_n_oe) |-> hold_cnt >= int'(RST_TIMEOUT_CYC))
    else $error("reset released too soon after its source");
  AST_REL_LEN: assert property ($fell(reset_n_oe) |-> rst_cnt >= int'(RST_TIMEOUT_CYC))
    else $error("reset pulse shorter than timeout");
  AST_MR_LONG: assert property (mr_low == int'(MR_MIN_CYC) + 8 |-> reset_n_oe)
    else $error("long manual reset not accepted");
  AST_CE_BLOCK: assert property (reset_n_oe && ce_out_n ##1 reset_n_oe |-> ce_out_n)
    else $error("chip enable passed in reset");
  AST_CE_DRAIN: assert property (rst_cnt > DRAIN |-> ce_out_n)
    else $error("chip enable held past write completion");
  AST_CE_PASS: assert property ((!reset_n_oe && $stable(ce_in_n))[*8] |-> ce_out_n == ce_in_n)
    else $error("chip enable not passed when idle");
  AST_BK_LEAVE: assert property (supply_ok[*6] |-> !on_backup_supply_n_oe)
    else $error("backup output active on good supply");
  COV_RST: cover property (rst_cnt == int'(RST_TIMEOUT_CYC));
  COV_BK: cover property ($rose(on_backup_supply_n_oe));
  COV_DRAIN: cover property (rst_cnt == DRAIN + 5);
endmodule

bind csw_top csw_top_checker #(.RST_TIMEOUT_CYC(RST_TIMEOUT_CYC), .MR_MIN_CYC(MR_MIN_CYC)) chk (.hclk, .hresetn,
  .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .supply_ok, .manual_reset_n, .ce_in_n, .ce_out_n,
  .reset_n_o, .reset_n_oe, .on_backup_supply_n_o, .on_backup_supply_n_oe, .serial_out_en);
`default_nettype wire

// >>> sim/csw_top_bench.sv
// Self-checking bench of the supervisor block
`timescale 1ns/10ps
`default_nettype none

module csw_top_bench;
  localparam int unsigned WL = 400;
  localparam int unsigned WS = 50;
  localparam int unsigned RT = 100;
  localparam int unsigned BH = 20;
  localparam int unsigned OF = 60;
  localparam int unsigned MM = 250;
  localparam logic [31:0] CA = 32'(csw_pkg::CTRL_OFS);
  localparam logic [31:0] SA = 32'(csw_pkg::STAT_OFS);
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, osc_in, supply_ok, vcc_below_batt;
  logic manual_reset_n, watchdog_kick_in, ce_in_n, ce_out_n, reset_n_oe, on_backup_supply_n_oe, serial_out_en;
  logic osc_run, kick_run;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  int err_count = 0;
  int checks_done = 0;
  assign hready = hreadyout;
  csw_top #(.WD_LONG_CYC(WL), .WD_SHORT_CYC(WS), .RST_TIMEOUT_CYC(RT), .BLINK_HALF_CYC(BH), .OSC_FAIL_CYC(OF),
    .MR_MIN_CYC(MM)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .osc_in, .supply_ok, .vcc_below_batt, .manual_reset_n, .watchdog_kick_in, .ce_in_n, .ce_out_n,
    .reset_n_o(), .reset_n_oe, .on_backup_supply_n_o(), .on_backup_supply_n_oe, .serial_out_en);
  csw_host_model host (.hclk, .osc_run, .kick_run, .osc_in, .watchdog_kick_in);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = !hclk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic rdy_edge();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      err_count++;
      $display("BAD hready exp 1 got %b", hready);
      final_report();
    end
  endtask
  // Data taken at the data phase edge, before that edge lands
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_edge();
    rdat = hrdata;
  endtask
  task automatic wait_oe(input logic v, output int n);
    n = 0;
    while (reset_n_oe !== v)
    begin
      @(posedge hclk);
      n++;
      if (n > 3000)
      begin
        err_count++;
        $display("BAD reset_n_oe exp %b got %b", v, reset_n_oe);
        final_report();
      end
    end
  endtask
  function automatic logic [31:0] cv(input logic en, input logic per, input logic bl, input logic osc);
    cv = 32'h0;
    cv[csw_pkg::WATCHDOG_ENABLE_BIT_POS] = en;
    cv[csw_pkg::WD_PERIOD_POS] = per;
    cv[csw_pkg::BLINK_POS] = bl;
    cv[csw_pkg::OSC_EN_POS] = osc;
  endfunction
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int n;
    int i;
    int len;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, vcc_below_batt} = '0;
    {supply_ok, manual_reset_n, ce_in_n, osc_run, kick_run} = '1;
    hsize = 3'h2;
    n = $urandom(32'h46F1);
    cyc(2);
    hresetn <= 1'b1;
    bus(1'b0, CA, 32'h0);
    chk32("ctrl_por", cv(1, 0, 0, 1), rdat);
    chk1("rst_hold", 1'b1, reset_n_oe);
    chk1("ser_off", 1'b0, serial_out_en);
    wait_oe(1'b0, n);
    chk1("rst_len", 1'b1, n > RT - 10);
    bus(1'b0, SA, 32'h0);
    bus(1'b0, SA, 32'h0);
    chk1("osc_ok", 1'b0, rdat[csw_pkg::OSC_FAIL_POS]);
    osc_run <= 1'b0;
    cyc(OF + 20);
    for (i = 0; i < 3; i++)
    begin
      bus(1'b0, SA, 32'h0);
      chk1("osc_fail", 1'b1, rdat[csw_pkg::OSC_FAIL_POS]);
      osc_run <= (i != 0);
      cyc(20);
    end
    bus(1'b0, SA, 32'h0);
    chk1("osc_clr", 1'b0, rdat[csw_pkg::OSC_FAIL_POS]);
    bus(1'b1, CA, cv(1, 1, 0, 1));
    cyc(200);
    chk1("kick_keeps", 1'b0, reset_n_oe);
    kick_run <= 1'b0;
    wait_oe(1'b1, n);
    chk1("wd_short", 1'b1, n > WS - 15 && n < WS + 10);
    wait_oe(1'b0, n);
    chk1("wd_rst_len", 1'b1, n >= RT - 2);
    bus(1'b0, CA, 32'h0);
    chk32("ctrl_wd", cv(0, 0, 0, 1), rdat);
    cyc(WL + 50);
    chk1("wd_off", 1'b0, reset_n_oe);
    bus(1'b1, CA, cv(1, 0, 0, 1));
    wait_oe(1'b1, n);
    chk1("wd_long", 1'b1, n > WL - 5 && n < WL + 10);
    wait_oe(1'b0, n);
    bus(1'b1, CA, cv(0, 0, 0, 0));
    osc_run <= 1'b0;
    cyc(OF + 20);
    bus(1'b0, SA, 32'h0);
    chk1("osc_off", 1'b0, rdat[csw_pkg::OSC_FAIL_POS]);
    bus(1'b1, CA, cv(0, 1, 1, 1));
    osc_run <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      len = (i == 0) ? MM - 10 : 1 + $urandom % 8;
      manual_reset_n <= 1'b0;
      cyc(len);
      manual_reset_n <= 1'b1;
      cyc(20);
    end
    chk1("mr_glitch", 1'b0, reset_n_oe);
    manual_reset_n <= 1'b0;
    cyc(MM + 20);
    chk1("mr_assert", 1'b1, reset_n_oe);
    manual_reset_n <= 1'b1;
    wait_oe(1'b0, n);
    chk1("mr_tail", 1'b1, n >= RT);
    bus(1'b0, CA, 32'h0);
    chk32("ctrl_mr", cv(0, 0, 1, 1), rdat);
    for (i = 0; i < 20; i++)
    begin
      ce_in_n <= 1'($urandom % 2);
      cyc(10);
      chk1("ce_pass", ce_in_n, ce_out_n);
    end
    ce_in_n <= 1'b0;
    cyc(10);
    supply_ok <= 1'b0;
    cyc(10);
    chk1("bk_need_batt", 1'b0, on_backup_supply_n_oe);
    chk1("rst_supply", 1'b1, reset_n_oe);
    vcc_below_batt <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      cyc(i == 0 ? 10 : BH);
      chk1("bk_blink", 1'(i % 2 == 0), on_backup_supply_n_oe);
    end
    bus(1'b0, SA, 32'h0);
    chk1("st_rst", 1'b1, rdat[csw_pkg::RST_ACTIVE_POS]);
    chk1("st_bk", 1'b1, rdat[csw_pkg::ON_BACKUP_POS]);
    cyc(2300);
    chk1("ce_drain", 1'b0, ce_out_n);
    cyc(200);
    chk1("ce_gate", 1'b1, ce_out_n);
    ce_in_n <= 1'b1;
    cyc(10);
    ce_in_n <= 1'b0;
    cyc(10);
    chk1("ce_blocked", 1'b1, ce_out_n);
    supply_ok <= 1'b1;
    vcc_below_batt <= 1'b0;
    cyc(8);
    chk1("bk_off", 1'b0, on_backup_supply_n_oe);
    wait_oe(1'b0, n);
    chk1("rst_rise", 1'b1, n >= RT - 10);
    cyc(10);
    chk1("ce_reopen", 1'b0, ce_out_n);
    final_report();
  end
endmodule
`default_nettype wire
